// [src/adc_serial_pkg.sv]
package adc_serial_pkg;

  localparam int WORD_BITS = 24;
  localparam int FIFO_DEPTH = 8;

  // ref_clk doubles as the converter's master clock
  localparam int REF_PERIOD_NS = 8;
  localparam int MCLK_PERIOD_NS = 8;

  // host limits and device answer, in master clock periods
  localparam int ADDR_SETUP_PERIODS = 2;
  localparam int DATA_ACCESS_PERIODS = 4;
  localparam int SCLK_PHASE_PERIODS = 2;
  localparam int SCLK_DIVIDE_MIN = 5;
  localparam int WRITE_HOLD_PERIODS = 4;

  // least times round up to whole cycles, longest times round down
  localparam int ADDR_SETUP_CYC =
    (ADDR_SETUP_PERIODS * MCLK_PERIOD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int DATA_ACCESS_CYC = (DATA_ACCESS_PERIODS * MCLK_PERIOD_NS) / REF_PERIOD_NS;
  localparam int SCLK_PHASE_CYC =
    (SCLK_PHASE_PERIODS * MCLK_PERIOD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int WRITE_HOLD_CYC =
    (WRITE_HOLD_PERIODS * MCLK_PERIOD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

  // self-clocking phases generated by the device
  localparam int SELF_LOW_CYC = 8;
  localparam int SELF_HIGH_CYC = 2;
  // external clock phase generated by the host
  localparam int HOST_PHASE_CYC = 4;

  localparam logic [WORD_BITS-1:0] CTRL_RESET = 24'h000000;
  localparam logic [WORD_BITS-1:0] CAL_RESET = 24'h000000;
  localparam logic [WORD_BITS-1:0] DATA_RESET = 24'h000000;
  localparam int CAL_READ_BIT = 0;

  typedef enum logic [1:0] {XFER_IDLE, XFER_READ, XFER_WRITE, XFER_DONE} xfer_t;
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_SELF, H_HOLD} host_state_t;

endpackage

// [src/adc_serial_if.sv]
interface adc_serial_if;
  logic registerSelect;
  logic readFrameStrobeN;
  logic writeFrameStrobeN;
  logic conversionReadyN;
  logic selfClockMode;
  logic filterSync;
  logic devSclkOut;
  logic devSclkOe;
  logic hostSclkOut;
  logic hostSclkOe;
  logic devDataOut;
  logic devDataOe;
  logic hostDataOut;
  logic hostDataOe;
  wire sclk;
  wire sdata;

  // undriven lines sit high, as with a pull-up
  assign sclk = devSclkOe ? devSclkOut : (hostSclkOe ? hostSclkOut : 1'b1);
  assign sdata = devDataOe ? devDataOut : (hostDataOe ? hostDataOut : 1'b1);

  modport device (
    input registerSelect, readFrameStrobeN, writeFrameStrobeN, selfClockMode, filterSync,
    input sclk, sdata,
    output conversionReadyN, devSclkOut, devSclkOe, devDataOut, devDataOe
  );

  modport host (
    output registerSelect, readFrameStrobeN, writeFrameStrobeN, selfClockMode, filterSync,
    input sclk, sdata, conversionReadyN,
    output hostSclkOut, hostSclkOe, hostDataOut, hostDataOe
  );
endinterface

// [src/adc_serial_device.sv]

module sync_fifo #(
  parameter int WIDTH = adc_serial_pkg::WORD_BITS,
  parameter int DEPTH = adc_serial_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  wire [AW-1:0] lastIdx = AW'(DEPTH - 1);

  assign inReady = count_q != (AW + 1)'(DEPTH);
  assign outValid = count_q != '0;
  assign outData = mem_q[rdPtr_q];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == lastIdx) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == lastIdx) ? '0 : rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // sync_fifo

module adc_serial_device #(
  parameter int WORD_BITS = adc_serial_pkg::WORD_BITS,
  parameter int FIFO_DEPTH = adc_serial_pkg::FIFO_DEPTH,
  parameter int SELF_LOW_CYC = adc_serial_pkg::SELF_LOW_CYC,
  parameter int SELF_HIGH_CYC = adc_serial_pkg::SELF_HIGH_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  adc_serial_if.device link,
  input wire logic [WORD_BITS-1:0] convData,
  input wire logic convValid,
  output logic convReady,
  output logic [WORD_BITS-1:0] ctrlWord,
  output logic filterReset
);
  localparam int BW = $clog2(WORD_BITS);
  localparam int CW = $clog2(SELF_LOW_CYC + SELF_HIGH_CYC);
  localparam logic [BW-1:0] LAST_BIT = BW'(WORD_BITS - 1);
  localparam logic [CW-1:0] LOW_END = CW'(SELF_LOW_CYC - 1);
  localparam logic [CW-1:0] HIGH_END = CW'(SELF_HIGH_CYC - 1);

  // pins from the far side pass two flip-flops; only pin_q is read by logic
  // reset holds the idle pin levels so no false edge or sync pulse follows reset
  logic [6:0] meta_q;
  logic [6:0] pin_q;
  wire [6:0] pinRaw = {link.sclk, link.sdata, link.readFrameStrobeN,
                       link.writeFrameStrobeN, link.registerSelect,
                       link.selfClockMode, link.filterSync};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 7'h78;
      pin_q <= 7'h78;
    end else begin
      meta_q <= pinRaw;
      pin_q <= meta_q;
    end
  end

  wire sclkIn = pin_q[6];
  wire dataIn = pin_q[5];
  wire readStrobeN = pin_q[4];
  wire writeStrobeN = pin_q[3];
  wire regSelect = pin_q[2];
  wire selfMode = pin_q[1];
  wire syncIn = pin_q[0];

  adc_serial_pkg::xfer_t xfer_q;
  logic [BW-1:0] bitCnt_q;
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] ctrl_q;
  logic [WORD_BITS-1:0] cal_q;
  logic [WORD_BITS-1:0] lastData_q;
  logic writeSel_q;
  logic sclkPrev_q;
  logic selfSclk_q;
  logic [CW-1:0] selfCnt_q;
  logic readyN_q;
  logic filterReset_q;

  wire fifoValid;
  wire [WORD_BITS-1:0] fifoData;
  wire popData;

  sync_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) conv_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(convValid),
    .inReady(convReady),
    .inData(convData),
    .outValid(fifoValid),
    .outReady(popData),
    .outData(fifoData)
  );

  // frame opening; read wins when both strobes fall together
  wire inIdle = xfer_q == adc_serial_pkg::XFER_IDLE;
  wire startRead = inIdle && !readStrobeN;
  wire startWrite = inIdle && readStrobeN && !writeStrobeN;
  wire calRead = ctrl_q[adc_serial_pkg::CAL_READ_BIT];
  wire [WORD_BITS-1:0] dataWord = fifoValid ? fifoData : lastData_q;
  wire [WORD_BITS-1:0] highWord = calRead ? cal_q : dataWord;
  wire [WORD_BITS-1:0] readWord = regSelect ? highWord : ctrl_q;
  assign popData = startRead && regSelect && !calRead && fifoValid;

  // serial clock generation while a self-clocked frame is shifting its word, stopped once done
  wire shifting = (xfer_q == adc_serial_pkg::XFER_READ) ||
                  (xfer_q == adc_serial_pkg::XFER_WRITE);
  wire genRun = selfMode && shifting;
  wire selfRise = genRun && !selfSclk_q && selfCnt_q == LOW_END;
  wire selfFall = genRun && selfSclk_q && selfCnt_q == HIGH_END;
  // edges of the host clock; pauses just mean no edge for a while
  wire extRise = !selfMode && !sclkPrev_q && sclkIn;
  wire extFall = !selfMode && sclkPrev_q && !sclkIn;
  wire riseEv = selfMode ? selfRise : extRise;
  wire fallEv = selfMode ? selfFall : extFall;
  wire lastBit = bitCnt_q == LAST_BIT;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      selfSclk_q <= 1'b0;
      selfCnt_q <= '0;
    end else if (!genRun) begin
      selfSclk_q <= 1'b0;
      selfCnt_q <= '0;
    end else if (selfRise || selfFall) begin
      selfSclk_q <= !selfSclk_q;
      selfCnt_q <= '0;
    end else begin
      selfCnt_q <= selfCnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      xfer_q <= adc_serial_pkg::XFER_IDLE;
      bitCnt_q <= '0;
      shift_q <= '0;
      writeSel_q <= 1'b0;
    end else begin
      unique case (xfer_q)
        adc_serial_pkg::XFER_IDLE: begin
          bitCnt_q <= '0;
          writeSel_q <= regSelect;
          if (startRead) begin
            // first bit is on the pin one edge after the strobe is seen
            shift_q <= readWord;
            xfer_q <= adc_serial_pkg::XFER_READ;
          end else if (startWrite) begin
            xfer_q <= adc_serial_pkg::XFER_WRITE;
          end
        end
        adc_serial_pkg::XFER_READ: begin
          if (readStrobeN) begin
            xfer_q <= adc_serial_pkg::XFER_IDLE;
          end else if (fallEv) begin
            shift_q <= {shift_q[WORD_BITS-2:0], 1'b0};
            bitCnt_q <= bitCnt_q + 1'b1;
            if (lastBit) begin
              xfer_q <= adc_serial_pkg::XFER_DONE;
            end
          end
        end
        adc_serial_pkg::XFER_WRITE: begin
          if (writeStrobeN) begin
            xfer_q <= adc_serial_pkg::XFER_IDLE;
          end else if (riseEv) begin
            shift_q <= {shift_q[WORD_BITS-2:0], dataIn};
            bitCnt_q <= bitCnt_q + 1'b1;
            if (lastBit) begin
              xfer_q <= adc_serial_pkg::XFER_DONE;
            end
          end
        end
        adc_serial_pkg::XFER_DONE: begin
          if (readStrobeN && writeStrobeN) begin
            xfer_q <= adc_serial_pkg::XFER_IDLE;
          end
        end
      endcase
    end
  end

  // a write only lands once all bits are in; a cut-short word is dropped
  wire commit = (xfer_q == adc_serial_pkg::XFER_WRITE) && !writeStrobeN && riseEv && lastBit;
  wire [WORD_BITS-1:0] writeWord = {shift_q[WORD_BITS-2:0], dataIn};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= adc_serial_pkg::CTRL_RESET;
      cal_q <= adc_serial_pkg::CAL_RESET;
      lastData_q <= adc_serial_pkg::DATA_RESET;
    end else begin
      if (commit && !writeSel_q) begin
        ctrl_q <= writeWord;
      end
      if (commit && writeSel_q) begin
        cal_q <= writeWord;
      end
      if (popData) begin
        lastData_q <= fifoData;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclkPrev_q <= 1'b1;
      readyN_q <= 1'b1;
      filterReset_q <= 1'b0;
    end else begin
      sclkPrev_q <= sclkIn;
      // ready drops while a conversion word waits, rises once its read begins
      readyN_q <= !fifoValid || popData || (xfer_q == adc_serial_pkg::XFER_READ);
      filterReset_q <= syncIn;
    end
  end

  assign link.devSclkOut = selfSclk_q;
  assign link.devSclkOe = genRun;
  assign link.devDataOut = shift_q[WORD_BITS-1];
  assign link.devDataOe = xfer_q == adc_serial_pkg::XFER_READ;
  assign link.conversionReadyN = readyN_q;
  assign ctrlWord = ctrl_q;
  assign filterReset = filterReset_q;
endmodule // adc_serial_device

// [src/adc_serial_host.sv]
module adc_serial_host #(
  parameter int WORD_BITS = adc_serial_pkg::WORD_BITS,
  parameter int PHASE_CYC = adc_serial_pkg::HOST_PHASE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  adc_serial_if.host link,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdWrite,
  input wire logic cmdSelect,
  input wire logic [WORD_BITS-1:0] cmdData,
  input wire logic selfClock,
  input wire logic syncRequest,
  output logic rspValid,
  output logic [WORD_BITS-1:0] rspData,
  output logic conversionReady
);
  localparam int BW = $clog2(WORD_BITS);
  localparam int CW = 4;
  localparam logic [BW-1:0] LAST_BIT = BW'(WORD_BITS - 1);
  localparam logic [CW-1:0] PHASE_END = CW'(PHASE_CYC - 1);
  // setup also covers the device's input synchroniser
  localparam logic [CW-1:0] SETUP_END = CW'(PHASE_CYC - 1);
  localparam logic [CW-1:0] HOLD_END = CW'(adc_serial_pkg::WRITE_HOLD_CYC - 1);

  logic [2:0] meta_q;
  logic [2:0] pin_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 3'h7;
      pin_q <= 3'h7;
    end else begin
      meta_q <= {link.sclk, link.sdata, link.conversionReadyN};
      pin_q <= meta_q;
    end
  end

  wire sclkIn = pin_q[2];
  wire dataIn = pin_q[1];

  adc_serial_pkg::host_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic [BW-1:0] bits_q;
  logic [WORD_BITS-1:0] shift_q;
  logic write_q;
  logic select_q;
  logic mode_q;
  logic rfsN_q;
  logic tfsN_q;
  logic sclk_q;
  logic sclkOe_q;
  logic sclkPrev_q;
  logic rspValid_q;
  logic sync_q;

  wire selfRise = !sclkPrev_q && sclkIn;
  wire selfFall = sclkPrev_q && !sclkIn;
  wire lastBit = bits_q == LAST_BIT;
  wire [WORD_BITS-1:0] shiftIn = {shift_q[WORD_BITS-2:0], dataIn};
  wire [WORD_BITS-1:0] shiftOut = {shift_q[WORD_BITS-2:0], 1'b0};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= adc_serial_pkg::H_IDLE;
      cnt_q <= '0;
      bits_q <= '0;
      shift_q <= '0;
      write_q <= 1'b0;
      select_q <= 1'b0;
      mode_q <= 1'b0;
      rfsN_q <= 1'b1;
      tfsN_q <= 1'b1;
      sclk_q <= 1'b0;
      sclkOe_q <= 1'b0;
      rspValid_q <= 1'b0;
    end else begin
      rspValid_q <= 1'b0;
      cnt_q <= cnt_q + 1'b1;
      unique case (state_q)
        adc_serial_pkg::H_IDLE: begin
          cnt_q <= '0;
          bits_q <= '0;
          mode_q <= selfClock;
          if (cmdValid) begin
            write_q <= cmdWrite;
            select_q <= cmdSelect;
            shift_q <= cmdData;
            // in external clocking, park the clock low before the strobe so the device sees no edge
            sclk_q <= 1'b0;
            sclkOe_q <= !selfClock;
            state_q <= adc_serial_pkg::H_SETUP;
          end
        end
        adc_serial_pkg::H_SETUP: begin
          if (cnt_q == SETUP_END) begin
            rfsN_q <= write_q;
            tfsN_q <= !write_q;
            cnt_q <= '0;
            state_q <= mode_q ? adc_serial_pkg::H_SELF : adc_serial_pkg::H_LOW;
          end
        end
        adc_serial_pkg::H_LOW: begin
          if (cnt_q == PHASE_END) begin
            sclk_q <= 1'b1;
            cnt_q <= '0;
            state_q <= adc_serial_pkg::H_HIGH;
          end
        end
        adc_serial_pkg::H_HIGH: begin
          if (cnt_q == PHASE_END) begin
            // read data is sampled late in the high phase, past the resync
            shift_q <= write_q ? shiftOut : shiftIn;
            sclk_q <= 1'b0;
            cnt_q <= '0;
            bits_q <= bits_q + 1'b1;
            state_q <= lastBit ? adc_serial_pkg::H_HOLD : adc_serial_pkg::H_LOW;
          end
        end
        adc_serial_pkg::H_SELF: begin
          cnt_q <= '0;
          if (selfRise) begin
            bits_q <= bits_q + 1'b1;
            if (!write_q) begin
              shift_q <= shiftIn;
            end
            if (lastBit) begin
              state_q <= adc_serial_pkg::H_HOLD;
            end
          end else if (selfFall && write_q && bits_q != '0) begin
            // the device's first drive of the clock is a fall from the pull-up level
            shift_q <= shiftOut;
          end
        end
        adc_serial_pkg::H_HOLD: begin
          if (cnt_q == HOLD_END) begin
            rfsN_q <= 1'b1;
            tfsN_q <= 1'b1;
            sclkOe_q <= 1'b0;
            rspValid_q <= !write_q;
            state_q <= adc_serial_pkg::H_IDLE;
          end
        end
        default: begin
          state_q <= adc_serial_pkg::H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclkPrev_q <= 1'b1;
      sync_q <= 1'b0;
    end else begin
      sclkPrev_q <= sclkIn;
      sync_q <= syncRequest;
    end
  end

  assign cmdReady = state_q == adc_serial_pkg::H_IDLE;
  assign rspValid = rspValid_q;
  assign rspData = shift_q;
  assign conversionReady = !pin_q[0];
  assign link.registerSelect = select_q;
  assign link.readFrameStrobeN = rfsN_q;
  assign link.writeFrameStrobeN = tfsN_q;
  assign link.selfClockMode = mode_q;
  assign link.filterSync = sync_q;
  assign link.hostSclkOut = sclk_q;
  assign link.hostSclkOe = sclkOe_q;
  assign link.hostDataOut = shift_q[WORD_BITS-1];
  assign link.hostDataOe = write_q && !tfsN_q;
endmodule // adc_serial_host

// [dv/adc_serial_asserts.sv]
module adc_serial_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic registerSelect,
  input wire logic readFrameStrobeN,
  input wire logic writeFrameStrobeN,
  input wire logic selfClockMode,
  input wire logic devSclkOe,
  input wire logic hostSclkOe,
  input wire logic devDataOe,
  input wire logic hostDataOe,
  input wire logic sclk
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ACCESS_CYC = adc_serial_pkg::DATA_ACCESS_CYC;
  logic sclkSeen_q;
  logic [3:0] lvlCnt_q;
  logic [3:0] lvlCnt_d;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // length of the level just ended, saturating so long pauses never wrap
  assign lvlCnt_d = (sclk != sclkSeen_q) ? 4'h1 : ((lvlCnt_q == 4'hF) ? lvlCnt_q : lvlCnt_q + 4'h1);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclkSeen_q <= 1'b1;
      lvlCnt_q <= 4'h0;
    end else begin
      sclkSeen_q <= sclk;
      lvlCnt_q <= lvlCnt_d;
    end
  end

  a_host_quiet_self: assert property (selfClockMode && $past(selfClockMode) |-> !hostSclkOe)
    else $error("host drives serial clock in self clocking");
  a_dev_quiet_ext: assert property (!selfClockMode && $past(selfClockMode) == 1'b0 |-> !devSclkOe)
    else $error("device drives serial clock in external clocking");
  a_self_clk_start: assert property (($fell(readFrameStrobeN) || $fell(writeFrameStrobeN))
      && selfClockMode |-> ##[1:8] devSclkOe)
    else $error("self clock not started after strobe fall");
  a_self_clk_release: assert property ((readFrameStrobeN && writeFrameStrobeN) [*4] |-> !devSclkOe)
    else $error("self clock still driven with strobes high");
  a_first_bit_time: assert property ($fell(readFrameStrobeN) |-> ##[1:ACCESS_CYC] devDataOe)
    else $error("read data not driven in time");
  a_data_oe_strobe: assert property ($rose(devDataOe) |-> !readFrameStrobeN && !hostDataOe)
    else $error("device data driven outside read frame");
  a_select_setup: assert property ($fell(readFrameStrobeN) && !selfClockMode
      |-> $stable(registerSelect) && registerSelect == $past(registerSelect, 2))
    else $error("select changed too close to read strobe");
  a_phase_min: assert property (hostSclkOe && $past(hostSclkOe) && !selfClockMode
      && sclk != sclkSeen_q |-> lvlCnt_q >= 4'h2)
    else $error("external clock phase too short");
  a_write_hold: assert property ($fell(sclk) && hostSclkOe && !writeFrameStrobeN
      |-> !writeFrameStrobeN [*4])
    else $error("write strobe released too soon after clock fall");
  a_no_contend: assert property (!(devSclkOe && hostSclkOe))
    else $error("both ends drive serial clock");
endmodule // adc_serial_asserts

// [dv/adc_serial_port_control_tb.sv]
module adc_serial_port_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmdValid = 1'b0, cmdWrite = 1'b0, cmdSelect = 1'b0, selfClock = 1'b0;
  logic syncRequest = 1'b0, convValid = 1'b0;
  logic [23:0] cmdData = 24'h000000, convData = 24'h000000, q;
  logic cmdReady, rspValid, conversionReady, convReady, filterReset;
  logic [23:0] rspData, ctrlWord, ctrlWord2;
  int bad_count = 0, checks_done = 0, devDrv = 0, hostDrv = 0;

  adc_serial_if lnk();
  adc_serial_if lnk2();
  adc_serial_device i_adc_serial_device (.ref_clk(ref_clk), .rst(rst), .link(lnk),
    .convData(convData), .convValid(convValid), .convReady(convReady), .ctrlWord(ctrlWord),
    .filterReset(filterReset));
  // second device faces the bench directly so the clock can pause mid-word
  adc_serial_device i_adc_serial_device_b (.ref_clk(ref_clk), .rst(rst), .link(lnk2),
    .convData(24'h000000), .convValid(1'b0), .convReady(), .ctrlWord(ctrlWord2),
    .filterReset());
  adc_serial_host i_adc_serial_host (.ref_clk(ref_clk), .rst(rst), .link(lnk),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdSelect(cmdSelect),
    .cmdData(cmdData), .selfClock(selfClock), .syncRequest(syncRequest), .rspValid(rspValid),
    .rspData(rspData), .conversionReady(conversionReady));
  adc_serial_asserts i_adc_serial_asserts (.ref_clk(ref_clk), .rst(rst),
    .registerSelect(lnk.registerSelect), .readFrameStrobeN(lnk.readFrameStrobeN),
    .writeFrameStrobeN(lnk.writeFrameStrobeN), .selfClockMode(lnk.selfClockMode),
    .devSclkOe(lnk.devSclkOe), .hostSclkOe(lnk.hostSclkOe), .devDataOe(lnk.devDataOe),
    .hostDataOe(lnk.hostDataOe), .sclk(lnk.sclk));

  always #4 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (lnk.devSclkOe === 1'b1) devDrv++;
    if (lnk.hostSclkOe === 1'b1) hostDrv++;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up();
    bad_count++;
    $display("ERROR at %0t seen %h expected %h", $time, 24'h0, 24'h1);
    stop_test();
  endtask

  // one host command; bounded wait for completion, read word returned in rd
  task automatic cmd(input logic wr, input logic sel, input logic self,
                     input logic [23:0] d, output logic [23:0] rd);
    int n;
    int dv;
    int hv;
    dv = devDrv;
    hv = hostDrv;
    n = 0;
    @(negedge ref_clk);
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdSelect = sel;
    cmdData = d;
    selfClock = self;
    while (cmdReady !== 1'b1) begin
      @(negedge ref_clk);
      if (++n > 100) give_up();
    end
    @(negedge ref_clk);
    cmdValid = 1'b0;
    n = 0;
    while (wr ? (cmdReady !== 1'b1) : (rspValid !== 1'b1)) begin
      @(negedge ref_clk);
      if (++n > 2000) give_up();
    end
    rd = rspData;
    if (!wr) @(negedge ref_clk);
    chk(24'(devDrv > dv), 24'(self));
    chk(24'(hostDrv > hv), 24'(!self));
  endtask

  // write into the second device with a pause in the middle of the word
  task automatic paused_write(input logic [23:0] w);
    lnk2.hostSclkOut = 1'b0;
    lnk2.hostSclkOe = 1'b1;
    repeat (4) @(negedge ref_clk);
    lnk2.writeFrameStrobeN = 1'b0;
    lnk2.hostDataOe = 1'b1;
    // the link clock keeps its own 125 ns period, kept off the ref_clk edges
    #0.25;
    for (int i = 23; i >= 0; i--) begin
      lnk2.hostDataOut = w[i];
      #62.5;
      lnk2.hostSclkOut = 1'b1;
      #62.5;
      lnk2.hostSclkOut = 1'b0;
      if (i == 12) begin
        repeat (40) @(negedge ref_clk);
        #0.25;
      end
    end
    repeat (6) @(negedge ref_clk);
    lnk2.writeFrameStrobeN = 1'b1;
    lnk2.hostDataOe = 1'b0;
    lnk2.hostSclkOe = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  initial begin
    int n;
    lnk2.registerSelect = 1'b0;
    lnk2.readFrameStrobeN = 1'b1;
    lnk2.writeFrameStrobeN = 1'b1;
    lnk2.selfClockMode = 1'b0;
    lnk2.filterSync = 1'b0;
    lnk2.hostSclkOut = 1'b0;
    lnk2.hostSclkOe = 1'b0;
    lnk2.hostDataOut = 1'b0;
    lnk2.hostDataOe = 1'b0;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    chk(ctrlWord, 24'h000000);
    chk(24'({lnk.readFrameStrobeN, lnk.writeFrameStrobeN}), 24'h000003);
    chk(24'(conversionReady), 24'h000000);
    $display("test reset done");

    cmd(1'b1, 1'b0, 1'b0, 24'hA5C3F0, q);
    chk(ctrlWord, 24'hA5C3F0);
    cmd(1'b0, 1'b0, 1'b0, 24'h000000, q);
    chk(q, 24'hA5C3F0);
    cmd(1'b0, 1'b0, 1'b1, 24'h000000, q);
    chk(q, 24'hA5C3F0);
    $display("test control register done");

    cmd(1'b1, 1'b1, 1'b1, 24'h3C5A97, q);
    chk(ctrlWord, 24'hA5C3F0);
    cmd(1'b1, 1'b0, 1'b0, 24'hA5C3F1, q);
    cmd(1'b0, 1'b1, 1'b0, 24'h000000, q);
    chk(q, 24'h3C5A97);
    cmd(1'b1, 1'b0, 1'b1, 24'hA5C3F0, q);
    chk(ctrlWord, 24'hA5C3F0);
    $display("test calibration done");

    for (int i = 0; i < 9; i++) begin
      @(negedge ref_clk);
      convData = 24'h100000 + 24'(i);
      convValid = 1'b1;
      chk(24'(convReady), 24'(i < 8));
    end
    @(negedge ref_clk);
    convValid = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(24'(conversionReady), 24'h000001);
    for (int i = 0; i < 8; i++) begin
      cmd(1'b0, 1'b1, 1'(i), 24'h000000, q);
      chk(q, 24'h100000 + 24'(i));
    end
    repeat (6) @(negedge ref_clk);
    chk(24'(conversionReady), 24'h000000);
    $display("test conversion buffer done");

    syncRequest = 1'b1;
    n = 0;
    while (filterReset !== 1'b1) begin
      @(negedge ref_clk);
      if (++n > 10) give_up();
    end
    chk(24'(filterReset), 24'h000001);
    syncRequest = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(24'(filterReset), 24'h000000);
    $display("test filter sync done");

    paused_write(24'h5E1D2B);
    chk(ctrlWord2, 24'h5E1D2B);
    $display("test paused clock done");
    stop_test();
  end
endmodule // adc_serial_port_control_tb
